// ---- inc/spm_pkg.sv ----
/*
  Package for the serial port pin multiplexer: register offsets, field
  positions and reset values.
  Assumes a 250 MHz system clock and an APB register bus.
*/
package spm_pkg;
  // register byte addresses
  localparam logic [7:0] SPM_ADDR_PIN_FUNC = 8'h1C;
  localparam logic [7:0] SPM_ADDR_DIR = 8'h24;
  localparam logic [7:0] SPM_ADDR_OPEN_DRAIN = 8'h28;
  localparam logic [7:0] SPM_ADDR_PORT_OUT = 8'h20;
  localparam logic [7:0] SPM_ADDR_CTRL_ONE = 8'hB4;
  localparam logic [7:0] SPM_ADDR_CTRL_TWO = 8'hB0;
  localparam logic [7:0] SPM_ADDR_STATUS = 8'hB8;
  localparam logic [7:0] SPM_ADDR_DATA = 8'hBC;
  localparam logic [7:0] SPM_ADDR_SPI_CTRL = 8'hA0;
  localparam logic [7:0] SPM_ADDR_BAUD_DIV = 8'hC0;
  localparam logic [7:0] SPM_ADDR_PIN_STATE = 8'hC4;
  // reset values
  localparam logic [5:0] SPM_RST_PIN_FUNC = 6'h3C;
  localparam logic [5:0] SPM_RST_DIR = 6'h00;
  localparam logic [6:0] SPM_RST_OPEN_DRAIN = 7'h00;
  localparam logic [15:0] SPM_RST_BAUD_DIV = 16'h0010;
  // field positions
  localparam int SPM_FN_SINGLE_WIRE = 0;
  localparam int SPM_FN_PIN2_LO = 2;
  localparam int SPM_FN_PIN2_HI = 3;
  localparam int SPM_FN_PIN5_LO = 4;
  localparam int SPM_FN_PIN5_HI = 5;
  localparam int SPM_C1_NINE_BIT = 4;
  localparam int SPM_C1_TX_NINTH = 6;
  localparam int SPM_C1_RX_NINTH = 7;
  localparam int SPM_C2_RX_EN = 2;
  localparam int SPM_C2_TX_EN = 3;
  localparam int SPM_C2_RX_IE = 5;
  localparam int SPM_C2_TC_IE = 6;
  localparam int SPM_C2_TX_IE = 7;
  localparam int SPM_SPI_MASTER = 4;
  localparam int SPM_SPI_ENABLE = 6;
  localparam int SPM_NUM_PINS = 6;
endpackage

// ---- design/spm_pin_mux.sv ----
/*
  Serial port pin multiplexer with an asynchronous serial data path.
  Six port pins are shared between general I/O, the SPI pins, two
  interrupt lines and the serial transmit/receive pins.
  Assumes an APB master, a single 250 MHz clock, and pins resolved
  outside from the out/oe/pull-up signals.
*/
// Register access over APB and the address map were chosen for this implementation.
// Function
// [RQ1] general I/O direction follows direction bit
// [RQ2] select pin driver: master or direction bit
// [RQ3] unused interrupt/select inputs read high internally
// [RQ4] pins 4,3: I/O or MOSI/SCK
// [RQ5] pin 2 function from control bits 3:2
// [RQ6] SPI input pins have no pull-up
// [RQ7] SPI output pins honour open-drain bit
// [RQ8] open-drain bit: 0 push-pull, 1 open-drain
// [RQ9] two-wire: transmit pin 1, receive pin 0
// [RQ10] single-wire uses only pin 1
// [RQ11] single-wire both enabled loops transmit to receive
// [RQ12] no pull-up on serial receive pin
// [RQ13] transmit pin open-drain or push-pull
// [RQ14] frame: start, eight/nine data, stop
// [RQ15] common format and rate, independent directions
// [RQ16] data read gives receive, write loads transmit
// [RQ17] transmit data moves parallel into shifter
// [RQ18] full receive shifter loads receive data
// [RQ19] ninth bit accessed before data register
// [RQ20] interrupt only when enable set; flags auto-clear
// [RQ21] open-drain drives low, releases for one
module spm_pin_mux
  import spm_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // port pins
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe_out,
  output logic [5:0] pin_pullup_out,
  // spi engine side
  input wire logic spi_mosi_in,
  input wire logic spi_sck_in,
  input wire logic spi_miso_in,
  output logic spi_mosi_out,
  output logic spi_sck_out,
  output logic spi_miso_out,
  output logic spi_ss_n_out,
  // interrupt lines towards the cpu
  output logic irq_n_out,
  output logic nmi_n_out,
  output logic serial_irq_out
);
  logic [5:0] pin_func_q;
  logic [5:0] port_direction_reg_q;
  logic [6:0] port_open_drain_select_q;
  logic [5:0] port_out_q;
  logic master_select_q, serial_periph_enable_q;
  logic nine_bit_q, tx_ninth_bit_q, rx_ninth_bit_q;
  logic [7:0] ctrl_two_q;
  logic [15:0] baud_div_q;
  logic [7:0] tx_data_q, rx_data_q;
  logic tdre_q, tc_q, rdrf_q, ovr_q;
  logic status_read_q;
  logic [5:0] func_oe, func_out, use_func;
  logic tx_enable, rx_enable, single_wire;
  logic tx_line, rx_line;
  logic wr_en, rd_en;

  assign tx_enable = ctrl_two_q[SPM_C2_TX_EN];
  assign rx_enable = ctrl_two_q[SPM_C2_RX_EN];
  assign single_wire = pin_func_q[SPM_FN_SINGLE_WIRE];
  assign wr_en = psel_in & penable_in & pwrite_in;
  assign rd_en = psel_in & penable_in & ~pwrite_in;
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;

  // function selection per pin
  always_comb begin
    use_func = 6'h00;
    func_oe = 6'h00;
    func_out = 6'h00;
    pin_pullup_out = 6'h00;
    // pin 5: select / interrupt / io
    if (pin_func_q[SPM_FN_PIN5_HI] && !pin_func_q[SPM_FN_PIN5_LO]) begin
      use_func[5] = 1'b1;
      pin_pullup_out[5] = 1'b1;
    end else if (pin_func_q[SPM_FN_PIN5_HI] && serial_periph_enable_q) begin
      use_func[5] = 1'b1;
      func_oe[5] = master_select_q | port_direction_reg_q[5]; // [RQ2]
      func_out[5] = port_out_q[5];
    end
    // pins 4,3: mosi and sck
    if (serial_periph_enable_q) begin
      use_func[4] = 1'b1;
      use_func[3] = 1'b1;
      func_oe[4] = master_select_q | port_direction_reg_q[4]; // [RQ4]
      func_oe[3] = master_select_q | port_direction_reg_q[3]; // [RQ4]
      func_out[4] = spi_mosi_in;
      func_out[3] = spi_sck_in;
    end
    // pin 2: nmi / miso / io
    if (pin_func_q[SPM_FN_PIN2_HI] && !pin_func_q[SPM_FN_PIN2_LO]) begin
      use_func[2] = 1'b1; // [RQ5]
      pin_pullup_out[2] = 1'b1;
    end else if (pin_func_q[SPM_FN_PIN2_HI] && serial_periph_enable_q) begin
      use_func[2] = 1'b1; // [RQ5]
      func_oe[2] = master_select_q | port_direction_reg_q[2];
      func_out[2] = spi_miso_in;
    end
    // pin 1: transmit and, in single-wire mode, receive
    if (tx_enable || (single_wire && rx_enable)) begin
      use_func[1] = 1'b1; // [RQ9] [RQ10]
      func_oe[1] = tx_enable;
      func_out[1] = tx_line;
    end
    // pin 0: receive only in two-wire mode
    if (!single_wire && rx_enable) begin
      use_func[0] = 1'b1; // [RQ9] [RQ12]
    end
    // general io pins get pull-up from direction bit; [RQ6] [RQ12]
    for (int i = 0; i < SPM_NUM_PINS; i++) begin
      if (!use_func[i]) begin
        pin_pullup_out[i] = port_direction_reg_q[i];
        func_oe[i] = port_direction_reg_q[i]; // [RQ1]
        func_out[i] = port_out_q[i];
      end
    end
  end

  // driver type per pin
  genvar g;
  generate
    for (g = 0; g < SPM_NUM_PINS; g++) begin : g_drv
      // open-drain pulls low for zero, releases for one [RQ21]
      always_comb begin
        if (port_open_drain_select_q[g]) begin // [RQ7] [RQ8] [RQ13]
          pin_out[g] = 1'b0;
          pin_oe_out[g] = func_oe[g] & ~func_out[g];
        end else begin
          pin_out[g] = func_out[g];
          pin_oe_out[g] = func_oe[g];
        end
      end
    end
  endgenerate

  // unused inputs read high internally; the pin itself is untouched
  assign irq_n_out = (pin_func_q[5:4] == 2'b10) ? pin_in[5] : 1'b1; // [RQ3]
  assign nmi_n_out = (pin_func_q[3:2] == 2'b10) ? pin_in[2] : 1'b1; // [RQ3]
  assign spi_ss_n_out = (use_func[5] && func_oe[5] == 1'b0 &&
                         pin_func_q[5:4] == 2'b11) ? pin_in[5] : 1'b1;
  assign spi_mosi_out = serial_periph_enable_q ? pin_in[4] : 1'b1;
  assign spi_sck_out = serial_periph_enable_q ? pin_in[3] : 1'b1;
  assign spi_miso_out = (serial_periph_enable_q && pin_func_q[3:2] == 2'b11)
                        ? pin_in[2] : 1'b1; // [RQ3]
  // single-wire with both enabled ties transmit onto receive [RQ11]
  assign rx_line = !rx_enable ? 1'b1 :
                   (single_wire && tx_enable) ? tx_line :
                   single_wire ? pin_in[1] : pin_in[0];

  // register writes
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pin_func_q <= SPM_RST_PIN_FUNC;
      port_direction_reg_q <= SPM_RST_DIR;
      port_open_drain_select_q <= SPM_RST_OPEN_DRAIN;
      port_out_q <= 6'h00;
      master_select_q <= 1'b0;
      serial_periph_enable_q <= 1'b0;
      nine_bit_q <= 1'b0;
      tx_ninth_bit_q <= 1'b0;
      ctrl_two_q <= 8'h00;
      baud_div_q <= SPM_RST_BAUD_DIV;
    end else if (wr_en) begin
      case (paddr_in)
        SPM_ADDR_PIN_FUNC: pin_func_q <= pwdata_in[5:0] & 6'h3D;
        SPM_ADDR_DIR: port_direction_reg_q <= pwdata_in[5:0];
        SPM_ADDR_OPEN_DRAIN: port_open_drain_select_q <= pwdata_in[6:0];
        SPM_ADDR_PORT_OUT: port_out_q <= pwdata_in[5:0];
        SPM_ADDR_SPI_CTRL: begin
          master_select_q <= pwdata_in[SPM_SPI_MASTER];
          serial_periph_enable_q <= pwdata_in[SPM_SPI_ENABLE];
        end
        SPM_ADDR_CTRL_ONE: begin
          nine_bit_q <= pwdata_in[SPM_C1_NINE_BIT];
          tx_ninth_bit_q <= pwdata_in[SPM_C1_TX_NINTH];
        end
        SPM_ADDR_CTRL_TWO: ctrl_two_q <= pwdata_in[7:0];
        SPM_ADDR_BAUD_DIV: baud_div_q <= pwdata_in[15:0];
        default: ;
      endcase
    end
  end

  // transmitter: one start, 8/9 data, one stop, shared rate [RQ14] [RQ15]
  typedef enum logic [1:0] {SPM_IDLE, SPM_SHIFT} spm_state_e;
  spm_state_e tx_st_q, rx_st_q;
  logic [15:0] tx_cnt_q, rx_cnt_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_bits_q, rx_bits_q;
  logic [8:0] rx_sh_q;
  logic tx_tick, rx_mid, rx_tick, data_wr, data_rd, rx_done;

  assign data_wr = wr_en && paddr_in == SPM_ADDR_DATA;
  assign data_rd = rd_en && paddr_in == SPM_ADDR_DATA;
  assign tx_tick = tx_cnt_q == 16'h0000;
  assign rx_tick = rx_cnt_q == 16'h0000;
  assign rx_mid = rx_cnt_q == {1'b0, baud_div_q[15:1]};
  assign tx_line = (tx_st_q == SPM_SHIFT) ? tx_sh_q[0] : 1'b1; // [RQ17]

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      tx_st_q <= SPM_IDLE;
      tx_cnt_q <= 16'h0000;
      tx_sh_q <= 11'h7FF;
      tx_bits_q <= 4'h0;
    end else begin
      case (tx_st_q)
        SPM_IDLE: begin
          if (tx_enable && !tdre_q) begin
            // parallel load, ninth bit taken as already written [RQ17] [RQ19]
            tx_sh_q <= nine_bit_q ? {1'b1, tx_ninth_bit_q, tx_data_q, 1'b0}
                                  : {2'b11, tx_data_q, 1'b0};
            tx_bits_q <= nine_bit_q ? 4'hB : 4'hA;
            tx_cnt_q <= baud_div_q;
            tx_st_q <= SPM_SHIFT;
          end
        end
        SPM_SHIFT: begin
          if (tx_tick) begin
            tx_cnt_q <= baud_div_q;
            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
            tx_bits_q <= tx_bits_q - 4'h1;
            if (tx_bits_q == 4'h1) tx_st_q <= SPM_IDLE;
          end else begin
            tx_cnt_q <= tx_cnt_q - 16'h0001;
          end
        end
        default: tx_st_q <= SPM_IDLE;
      endcase
    end
  end

  // receiver: sample at bit middle, load data register when full [RQ18]
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      rx_st_q <= SPM_IDLE;
      rx_cnt_q <= 16'h0000;
      rx_sh_q <= 9'h000;
      rx_bits_q <= 4'h0;
    end else begin
      case (rx_st_q)
        SPM_IDLE: begin
          if (!rx_line) begin
            rx_cnt_q <= baud_div_q;
            rx_bits_q <= nine_bit_q ? 4'hA : 4'h9;
            rx_st_q <= SPM_SHIFT;
          end
        end
        SPM_SHIFT: begin
          rx_cnt_q <= rx_tick ? baud_div_q : rx_cnt_q - 16'h0001;
          if (rx_mid) begin
            rx_bits_q <= rx_bits_q - 4'h1;
            if (rx_bits_q == 4'h0) rx_st_q <= SPM_IDLE;
            else if (rx_bits_q != (nine_bit_q ? 4'hA : 4'h9))
              rx_sh_q <= nine_bit_q ? {rx_line, rx_sh_q[8:1]}
                                    : {1'b0, rx_line, rx_sh_q[7:1]};
          end
        end
        default: rx_st_q <= SPM_IDLE;
      endcase
    end
  end
  assign rx_done = rx_st_q == SPM_SHIFT && rx_mid && rx_bits_q == 4'h0;

  // data register and flags; hardware set wins over the clear
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      tx_data_q <= 8'h00;
      rx_data_q <= 8'h00;
      rx_ninth_bit_q <= 1'b0;
      tdre_q <= 1'b1;
      tc_q <= 1'b1;
      rdrf_q <= 1'b0;
      ovr_q <= 1'b0;
      status_read_q <= 1'b0;
    end else begin
      if (data_wr) tx_data_q <= pwdata_in[7:0]; // [RQ16]
      if (tx_st_q == SPM_IDLE && tx_enable && !tdre_q) tdre_q <= 1'b1;
      else if (data_wr && status_read_q) tdre_q <= 1'b0; // [RQ20]
      if (tx_st_q == SPM_SHIFT && tx_tick && tx_bits_q == 4'h1) tc_q <= 1'b1;
      else if (data_wr && status_read_q) tc_q <= 1'b0; // [RQ20]
      if (rx_done) begin
        rx_data_q <= rx_sh_q[7:0]; // [RQ18]
        rx_ninth_bit_q <= nine_bit_q ? rx_sh_q[8] : rx_ninth_bit_q;
        rdrf_q <= 1'b1;
        if (rdrf_q) ovr_q <= 1'b1;
      end else if (data_rd && status_read_q) begin
        rdrf_q <= 1'b0; // [RQ20]
        ovr_q <= 1'b0;
      end
      if (rd_en && paddr_in == SPM_ADDR_STATUS) status_read_q <= 1'b1;
      else if (data_rd || data_wr) status_read_q <= 1'b0;
    end
  end

  // interrupt only from enabled flags [RQ20]
  assign serial_irq_out = (tdre_q & ctrl_two_q[SPM_C2_TX_IE]) |
                          (tc_q & ctrl_two_q[SPM_C2_TC_IE]) |
                          ((rdrf_q | ovr_q) & ctrl_two_q[SPM_C2_RX_IE]);

  // read data from flip-flops; unmapped addresses read zero
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      case (paddr_in)
        SPM_ADDR_PIN_FUNC: prdata_out <= {26'h0, pin_func_q};
        SPM_ADDR_DIR: prdata_out <= {26'h0, port_direction_reg_q};
        SPM_ADDR_OPEN_DRAIN: prdata_out <= {25'h0, port_open_drain_select_q};
        SPM_ADDR_PORT_OUT: prdata_out <= {26'h0, port_out_q};
        SPM_ADDR_SPI_CTRL:
          prdata_out <= {25'h0, serial_periph_enable_q, 1'b0,
                         master_select_q, 4'h0};
        SPM_ADDR_CTRL_ONE:
          prdata_out <= {24'h0, rx_ninth_bit_q, tx_ninth_bit_q, 1'b0,
                         nine_bit_q, 4'h0};
        SPM_ADDR_CTRL_TWO: prdata_out <= {24'h0, ctrl_two_q};
        SPM_ADDR_STATUS:
          prdata_out <= {24'h0, tdre_q, tc_q, rdrf_q, 1'b0, ovr_q, 3'h0};
        SPM_ADDR_DATA: prdata_out <= {24'h0, rx_data_q}; // [RQ16]
        SPM_ADDR_BAUD_DIV: prdata_out <= {16'h0, baud_div_q};
        SPM_ADDR_PIN_STATE: prdata_out <= {26'h0, pin_in};
        default: prdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // assertions
  a_gpio_dir_oe: assert property (@(posedge sys_clk_in) // [RQ1]
    disable iff (!nrst_in) !use_func[0] && !port_open_drain_select_q[0]
      |-> pin_oe_out[0] == port_direction_reg_q[0])
    else $error("gpio oe mismatch");
  a_ss_oe: assert property (@(posedge sys_clk_in) // [RQ2]
    disable iff (!nrst_in) serial_periph_enable_q && pin_func_q[5:4] == 2'b11
      && master_select_q && !port_open_drain_select_q[5] |-> pin_oe_out[5])
    else $error("select pin not driven");
  a_nmi_high: assert property (@(posedge sys_clk_in) // [RQ3]
    disable iff (!nrst_in) pin_func_q[3:2] != 2'b10 |-> nmi_n_out)
    else $error("unused nmi not high");
  a_spi_pullup: assert property (@(posedge sys_clk_in) // [RQ6]
    disable iff (!nrst_in)
    serial_periph_enable_q |-> !pin_pullup_out[4] && !pin_pullup_out[3])
    else $error("spi pin has pull-up");
  a_nmi_pin2: assert property (@(posedge sys_clk_in) // [RQ5]
    disable iff (!nrst_in)
    pin_func_q[3:2] == 2'b10 |-> pin_pullup_out[2] && !pin_oe_out[2])
    else $error("nmi pin config wrong");
  a_od_high: assert property (@(posedge sys_clk_in) // [RQ21]
    disable iff (!nrst_in) port_open_drain_select_q[1] |-> !pin_out[1])
    else $error("open drain drives high");
  a_rx_nopull: assert property (@(posedge sys_clk_in) // [RQ12]
    disable iff (!nrst_in) rx_enable && !single_wire |-> !pin_pullup_out[0])
    else $error("receive pin pulled up");
  a_loopback: assert property (@(posedge sys_clk_in) // [RQ11]
    disable iff (!nrst_in) single_wire && rx_enable && tx_enable
      |-> rx_line == tx_line)
    else $error("loopback broken");
  a_irq_gate: assert property (@(posedge sys_clk_in) // [RQ20]
    disable iff (!nrst_in) ctrl_two_q[7:5] == 3'b000 |-> !serial_irq_out)
    else $error("irq without enable");
  a_rx_load: assert property (@(posedge sys_clk_in) // [RQ18]
    disable iff (!nrst_in)
    rx_done |=> rdrf_q && rx_data_q == $past(rx_sh_q[7:0]))
    else $error("receive load failed");
endmodule

// ---- tb/spm_far_end.sv ----
/*
  Far-side asynchronous serial device: sends and captures NRZ frames.
  Assumes the bench sets the bit period in system clock cycles and
  that the line it watches is resolved by the bench.
*/
module spm_far_end (
  input wire logic clk_in,
  input wire logic line_in,
  input wire logic [15:0] bit_cyc_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // the line idles at the mark level between frames
  initial line_out = 1'b1;

  task automatic send_frame(input logic [8:0] d, input int n);
    int i;
    for (i = -1; i <= n; i++) begin  // start, data lsb first, stop
      @(posedge clk_in);
      line_out <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : d[i];
      repeat (bit_cyc_in - 16'd1) @(posedge clk_in);
    end
  endtask

  // ok is low if no start bit came or the stop bit was not high
  task automatic get_frame(input int n, output logic [8:0] d,
                           output logic ok);
    int i;
    d = '0;
    for (i = 0; i < 2000 && line_in; i++) @(posedge clk_in);
    // no start bit in time: report a bad frame at once
    if (line_in) begin
      ok = 1'b0;
      return;
    end
    repeat (bit_cyc_in / 16'd2) @(posedge clk_in);
    ok = !line_in;
    for (i = 0; i < n; i++) begin
      repeat (bit_cyc_in) @(posedge clk_in);
      d[i] = line_in;
    end
    repeat (bit_cyc_in) @(posedge clk_in);
    ok = ok & line_in;
  endtask
endmodule

// ---- tb/tb_top.sv ----
/*
  Self-checking bench for the serial port pin multiplexer.
  Assumes a zero-wait APB slave; pin 1 has a board pull-up, pin 0 is
  driven by the far-side model, pins 5..2 by the bench.
*/
module tb_top;
  import spm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic [5:0] pin_lvl, pin_out, pin_oe, pin_pu;
  logic [5:0] ext_val = 6'h3C;
  logic mosi = 1'b0;
  logic sck = 1'b0;
  logic miso = 1'b0;
  logic mosi_o, sck_o, ss_n, irq_n, nmi_n, sirq, far_line;
  logic slverr, miso_o;
  logic [15:0] bitc = 16'd17;
  logic [31:0] v;
  logic [8:0] d;
  logic ok;
  int errors = 0;
  int samples_checked = 0;
  localparam logic [7:0] CT2 = SPM_ADDR_CTRL_TWO;

  always #2 clk = ~clk;
  // a released pin shows its board level, never a stale drive
  always_comb
    for (int i = 0; i < 6; i++)
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : (i == 0) ? far_line :
                   (i == 1) ? 1'b1 : ext_val[i];

  spm_pin_mux uut (.sys_clk_in(clk), .nrst_in(nrst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(slverr), .pin_in(pin_lvl), .pin_out(pin_out),
    .pin_oe_out(pin_oe), .pin_pullup_out(pin_pu), .spi_mosi_in(mosi),
    .spi_sck_in(sck), .spi_miso_in(miso), .spi_mosi_out(mosi_o),
    .spi_sck_out(sck_o), .spi_miso_out(miso_o), .spi_ss_n_out(ss_n),
    .irq_n_out(irq_n), .nmi_n_out(nmi_n), .serial_irq_out(sirq));

  spm_far_end far (.clk_in(clk), .line_in(pin_lvl[1]),
    .bit_cyc_in(bitc), .line_out(far_line));

  task automatic finish_test;
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      finish_test;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    apb(1'b1, a, wd, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    apb(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  // status read first, then the data write, as the flag clear needs
  task automatic send(input logic [7:0] b);
    logic [31:0] x;
    apb(1'b0, SPM_ADDR_STATUS, 32'h0, x);
    chk({31'h0, x[7]}, 32'h1);
    wr(SPM_ADDR_DATA, {24'h0, b});
  endtask

  task automatic wait_rdrf;
    int n;
    v = 32'h0;
    for (n = 0; n < 300 && v[5] !== 1'b1; n++)
      apb(1'b0, SPM_ADDR_STATUS, 32'h0, v);
    if (n >= 300) begin
      errors++;
      finish_test;
    end
  endtask

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(SPM_ADDR_PIN_FUNC, 32'h3C);
    rd_chk(SPM_ADDR_OPEN_DRAIN, 32'h0);
    rd_chk(8'hFC, 32'h0);
    chk({slverr, pin_pu, pin_oe}, {1'b0, 6'h00, 6'h00});
    // general I/O: direction bits give output enable
    wr(SPM_ADDR_PIN_FUNC, 32'h0);
    wr(SPM_ADDR_DIR, 32'h2A);
    wr(SPM_ADDR_PORT_OUT, 32'h15);
    tick;
    chk({pin_oe, pin_pu}, {6'h2A, 6'h2A});
    chk(pin_out, 6'h15);
    chk({irq_n, nmi_n, ss_n, miso_o}, 4'hF);
    // spi master, then open drain on mosi and sck
    wr(SPM_ADDR_DIR, 32'h0);
    wr(SPM_ADDR_PIN_FUNC, 32'h3C);
    wr(SPM_ADDR_SPI_CTRL, 32'h50);
    @(posedge clk);
    mosi <= 1'b0;
    sck <= 1'b1;
    tick;
    chk({pin_oe[5:2], pin_pu[5:2]}, 8'hF0);
    chk(pin_out[4:3], 2'b01);
    wr(SPM_ADDR_OPEN_DRAIN, 32'h18);
    tick;
    chk({pin_oe[4:3], pin_out[4]}, 3'b100);
    // spi slave: pins are inputs, levels reach the engine
    wr(SPM_ADDR_OPEN_DRAIN, 32'h0);
    wr(SPM_ADDR_SPI_CTRL, 32'h40);
    @(posedge clk);
    ext_val <= 6'h10;
    tick;
    chk({pin_oe[5:2], pin_pu[5:2]}, 8'h00);
    chk({ss_n, mosi_o, sck_o, miso_o}, 4'h4);
    // interrupt line functions on pins 5 and 2
    wr(SPM_ADDR_PIN_FUNC, 32'h28);
    tick;
    chk({pin_pu[5:2], pin_oe[5:2]}, 8'h90);
    chk({irq_n, nmi_n, ss_n, miso_o}, 4'h3);
    // two-wire serial, eight and nine data bits
    wr(SPM_ADDR_SPI_CTRL, 32'h0);
    wr(SPM_ADDR_PIN_FUNC, 32'h0);
    wr(SPM_ADDR_BAUD_DIV, 32'h3);
    bitc = 16'd4;
    wr(CT2, 32'h0C);
    tick;
    chk({pin_oe[1], pin_pu[1:0]}, 3'b100);
    for (int nine = 0; nine < 2; nine++) begin
      wr(SPM_ADDR_CTRL_ONE, nine ? 32'h50 : 32'h0);
      send(8'hA5);
      far.get_frame(8 + nine, d, ok);
      chk({ok, d}, {1'b1, nine[0], 8'hA5});
      if (!ok) finish_test;
    end
    wr(SPM_ADDR_CTRL_ONE, 32'h0);
    wr(CT2, 32'h4C);
    tick;
    chk(sirq, 1'b1);
    wr(CT2, 32'h0C);
    tick;
    chk(sirq, 1'b0);
    far.send_frame(9'h03C, 8);
    wait_rdrf;
    wr(CT2, 32'h2C);
    tick;
    chk(sirq, 1'b1);
    rd_chk(SPM_ADDR_DATA, 32'h3C);
    tick;
    chk(sirq, 1'b0);
    // single wire: pin 0 stays I/O, transmit loops onto receive
    wr(CT2, 32'h0C);
    wr(SPM_ADDR_DIR, 32'h1);
    wr(SPM_ADDR_PIN_FUNC, 32'h1);
    tick;
    chk({pin_oe[1:0], pin_pu[1]}, 3'b110);
    wr(SPM_ADDR_OPEN_DRAIN, 32'h2);
    tick;
    chk(pin_oe[1], 1'b0);
    send(8'h5A);
    far.get_frame(8, d, ok);
    chk({ok, d}, {1'b1, 9'h05A});
    if (!ok) finish_test;
    wait_rdrf;
    rd_chk(SPM_ADDR_DATA, 32'h5A);
    finish_test;
  end
endmodule
